// ===== core/status_ctrl_pkg.sv
package status_ctrl_pkg;

  // System clock rate and the factory-reset hold time.
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned FACTORY_HOLD_S  = 10;
  localparam longint unsigned FACTORY_HOLD_CYC =
    longint'(FACTORY_HOLD_S) * longint'(CLK_HZ);

  // Length of the dark gap that marks one data activity event.
  localparam int unsigned FLASH_CYC       = 5_000_000;

  // Default serial frame: eight data bits, no parity, one stop bit.
  localparam logic [3:0] SER_DATA_BITS    = 4'h8;
  localparam logic       SER_PARITY_EN    = 1'h0;
  localparam logic [1:0] SER_STOP_BITS    = 2'h1;
  localparam logic       SER_FLOW_CTRL_EN = 1'h0;

  // Operating mode reported by the firmware.
  typedef enum logic [1:0] {
    MODE_DATA          = 2'b00,
    MODE_EXTENDED_DATA = 2'b01,
    MODE_COMMAND       = 2'b10
  } op_mode_t;

  // Link state of the serial port emulation.
  typedef enum logic [1:0] {
    LINK_IDLE       = 2'b00,
    LINK_CONNECTING = 2'b01,
    LINK_CONNECTED  = 2'b10
  } link_state_t;

  // Start-up action chosen from the switch levels.
  typedef enum logic [2:0] {
    BOOT_NORMAL     = 3'b000,
    BOOT_SER_DEF    = 3'b001,
    BOOT_LOADER     = 3'b010,
    BOOT_FACTORY    = 3'b011
  } boot_state_t;

  // Indicator pin levels, all active low.
  typedef struct packed {
    logic red_n;
    logic green_n;
    logic blue_n;
  } rgb_t;

  // Serial frame settings.
  typedef struct packed {
    logic [3:0] data_bits;
    logic       parity_en;
    logic [1:0] stop_bits;
    logic       flow_ctrl_en;
  } ser_cfg_t;

  localparam rgb_t RGB_OFF = 3'b111;

endpackage : status_ctrl_pkg

// ===== core/status_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Colour outputs are active low.
// - Idle: data green only, command red+green.
// - Connecting red+blue; connected blue only.
// - Connected indicator flashes on data activity.
// - Switch two low alone at start: restore serial defaults.
// - Switch two in operation requests wireless link.
// - Both switches low at start: boot-loader.
// - Both held ten seconds from start: factory defaults restored.
// - Reset input performs full system reset.
// - Serial defaults are 8N1, no flow control.
module status_ctrl (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic                        switch1_n,
  input  wire logic                        switch2_n,
  input  wire status_ctrl_pkg::op_mode_t   op_mode,
  input  wire status_ctrl_pkg::link_state_t link_state,
  input  wire logic                        data_activity,
  output status_ctrl_pkg::rgb_t            rgb_n,
  output logic                             connect_req,
  output logic                             ser_defaults_load,
  output status_ctrl_pkg::ser_cfg_t        ser_defaults,
  output logic                             bootloader_active,
  output logic                             factory_reset,
  output logic                             normal_run
);

  localparam int unsigned HOLD_W = 40;
  localparam logic [HOLD_W-1:0] HOLD_LAST =
    HOLD_W'(status_ctrl_pkg::FACTORY_HOLD_CYC - 1);
  localparam logic [22:0] FLASH_LAST =
    23'(status_ctrl_pkg::FLASH_CYC - 1);

  status_ctrl_pkg::boot_state_t boot_reg,  boot_next;
  logic                         sampled_reg, sampled_next;
  logic [HOLD_W-1:0]            hold_reg,  hold_next;
  logic                         hold_lost_reg, hold_lost_next;
  logic [22:0]                  flash_reg, flash_next;
  logic                         sw2_prev_reg, sw2_prev_next;
  status_ctrl_pkg::rgb_t        rgb_next;
  logic                         conn_next, load_next, boot_out_next;
  logic                         fact_next, run_next;

  // Start-up selection and hold timing; the selection reads the switches only once.
  always_comb begin
    boot_next    = boot_reg;
    sampled_next = 1'b1;
    hold_next    = hold_reg;
    hold_lost_next = hold_lost_reg;
    load_next    = 1'b0;
    fact_next    = 1'b0;
    if (!sampled_reg) begin
      if (!switch1_n && !switch2_n) begin
        boot_next = status_ctrl_pkg::BOOT_LOADER;
      end else if (switch1_n && !switch2_n) begin
        boot_next = status_ctrl_pkg::BOOT_SER_DEF;
        load_next = 1'b1;
      end else begin
        boot_next = status_ctrl_pkg::BOOT_NORMAL;
      end
    end else if (boot_reg == status_ctrl_pkg::BOOT_LOADER) begin
      // Only a hold unbroken since start-up counts: once either switch
      // lets go, a later press cannot start a new hold. Boot-loader stays.
      if (!switch1_n && !switch2_n && !hold_lost_reg) begin
        if (hold_reg == HOLD_LAST) begin
          boot_next = status_ctrl_pkg::BOOT_FACTORY;
          fact_next = 1'b1;
          load_next = 1'b1;
        end else begin
          hold_next = hold_reg + 1'b1;
        end
      end else begin
        hold_next      = '0;
        hold_lost_next = 1'b1;
      end
    end
  end

  // Flash timer and the connect request edge detector.
  always_comb begin
    flash_next    = flash_reg;
    sw2_prev_next = switch2_n;
    if (data_activity &&
        link_state == status_ctrl_pkg::LINK_CONNECTED) begin
      flash_next = FLASH_LAST;
    end else if (flash_reg != '0) begin
      flash_next = flash_reg - 1'b1;
    end
    run_next  = sampled_reg &&
                (boot_reg == status_ctrl_pkg::BOOT_NORMAL ||
                 boot_reg == status_ctrl_pkg::BOOT_SER_DEF);
    // Only a fresh press counts, so a held button asks once.
    conn_next = run_next && sw2_prev_reg && !switch2_n;
    boot_out_next = sampled_reg &&
                    (boot_reg == status_ctrl_pkg::BOOT_LOADER);
  end

  // Colour decode; a low level lights the colour.
  always_comb begin
    rgb_next = status_ctrl_pkg::RGB_OFF;
    unique case (link_state)
      status_ctrl_pkg::LINK_CONNECTING:
        rgb_next = 3'b010;
      status_ctrl_pkg::LINK_CONNECTED: begin
        // Blanking rather than toggling keeps each event visible.
        rgb_next = (flash_reg != '0) ? 3'b111 : 3'b110;
      end
      default: begin
        if (op_mode == status_ctrl_pkg::MODE_COMMAND) begin
          rgb_next = 3'b001;
        end else begin
          rgb_next = 3'b101;
        end
      end
    endcase
  end

  // All state falls to constants on the reset input.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg          <= status_ctrl_pkg::BOOT_NORMAL;
      sampled_reg       <= 1'b0;
      hold_reg          <= '0;
      hold_lost_reg     <= 1'b0;
      flash_reg         <= '0;
      sw2_prev_reg      <= 1'b1;
      rgb_n             <= status_ctrl_pkg::RGB_OFF;
      connect_req       <= 1'b0;
      ser_defaults_load <= 1'b0;
      bootloader_active <= 1'b0;
      factory_reset     <= 1'b0;
      normal_run        <= 1'b0;
    end else begin
      boot_reg          <= boot_next;
      sampled_reg       <= sampled_next;
      hold_reg          <= hold_next;
      hold_lost_reg     <= hold_lost_next;
      flash_reg         <= flash_next;
      sw2_prev_reg      <= sw2_prev_next;
      rgb_n             <= rgb_next;
      connect_req       <= conn_next;
      ser_defaults_load <= load_next;
      bootloader_active <= boot_out_next;
      factory_reset     <= fact_next;
      normal_run        <= run_next;
    end
  end

  // Constant default frame, presented with every load pulse.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ser_defaults <= '0;
    end else begin
      ser_defaults <= {status_ctrl_pkg::SER_DATA_BITS,
                       status_ctrl_pkg::SER_PARITY_EN,
                       status_ctrl_pkg::SER_STOP_BITS,
                       status_ctrl_pkg::SER_FLOW_CTRL_EN};
    end
  end

  sequence s_both_low;
    !switch1_n && !switch2_n;
  endsequence

  property p_idle_data;
    @(posedge clk_sys) disable iff (!rst_n)
    (link_state == status_ctrl_pkg::LINK_IDLE &&
     op_mode != status_ctrl_pkg::MODE_COMMAND) |=> (rgb_n == 3'b101);
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("Idle data mode colour wrong.");

  property p_idle_cmd;
    @(posedge clk_sys) disable iff (!rst_n)
    (link_state == status_ctrl_pkg::LINK_IDLE &&
     op_mode == status_ctrl_pkg::MODE_COMMAND) |=> (rgb_n == 3'b001);
  endproperty
  a_idle_cmd: assert property (p_idle_cmd)
    else $error("Idle command mode colour wrong.");

  property p_connecting;
    @(posedge clk_sys) disable iff (!rst_n)
    (link_state == status_ctrl_pkg::LINK_CONNECTING) |=>
      (rgb_n == 3'b010);
  endproperty
  a_connecting: assert property (p_connecting)
    else $error("Connecting colour wrong.");

  property p_flash;
    @(posedge clk_sys) disable iff (!rst_n)
    (data_activity && link_state == status_ctrl_pkg::LINK_CONNECTED)
      |=> ##1 (rgb_n.blue_n || link_state != status_ctrl_pkg::LINK_CONNECTED);
  endproperty
  a_flash: assert property (p_flash)
    else $error("Activity did not blank blue.");

  property p_loader;
    @(posedge clk_sys) disable iff (!rst_n)
    (!sampled_reg ##0 s_both_low) |=> ##1 bootloader_active;
  endproperty
  a_loader: assert property (p_loader)
    else $error("Boot-loader not entered.");

  property p_serdef;
    @(posedge clk_sys) disable iff (!rst_n)
    (!sampled_reg && switch1_n && !switch2_n) |=>
      ser_defaults_load ##1 !ser_defaults_load;
  endproperty
  a_serdef: assert property (p_serdef)
    else $error("Serial defaults not loaded once.");

  property p_connect;
    @(posedge clk_sys) disable iff (!rst_n)
    connect_req |-> (normal_run && !$past(switch2_n, 1) == 1'b1);
  endproperty
  a_connect: assert property (p_connect)
    else $error("Connect request outside normal run.");

  property p_factory;
    @(posedge clk_sys) disable iff (!rst_n)
    factory_reset |-> ($past(hold_reg) == HOLD_LAST && ser_defaults_load);
  endproperty
  a_factory: assert property (p_factory)
    else $error("Factory reset before the hold time.");

  property p_frame;
    @(posedge clk_sys) disable iff (!rst_n)
    ser_defaults_load |-> (ser_defaults == 8'h82);
  endproperty
  a_frame: assert property (p_frame)
    else $error("Default frame is not 8N1.");

endmodule : status_ctrl

// ===== verification/led_button_model.sv
`timescale 1ns/1ps
// Stands in for the RGB indicator and the two push buttons on the board.
module led_button_model (
  input  wire logic                  press1,
  input  wire logic                  press2,
  input  wire status_ctrl_pkg::rgb_t rgb_n,
  output logic                       switch1_n,
  output logic                       switch2_n,
  output logic [2:0]                 lit
);
  // A pressed button pulls its line low; the pull-up wins when released.
  assign switch1_n = ~press1;
  assign switch2_n = ~press2;
  // A colour glows while its cathode line is low.
  assign lit = ~rgb_n;
endmodule : led_button_model

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                         clk_sys = 1'b0;
  logic                         rst_n = 1'b0;
  logic                         press1 = 1'b0;
  logic                         press2 = 1'b0;
  logic                         data_activity = 1'b0;
  status_ctrl_pkg::op_mode_t    op_mode = status_ctrl_pkg::MODE_DATA;
  status_ctrl_pkg::link_state_t link_state = status_ctrl_pkg::LINK_IDLE;
  logic                         switch1_n;
  logic                         switch2_n;
  logic                         connect_req;
  logic                         ser_defaults_load;
  logic                         bootloader_active;
  logic                         factory_reset;
  logic                         normal_run;
  logic [2:0]                   lit;
  status_ctrl_pkg::rgb_t        rgb_n;
  status_ctrl_pkg::ser_cfg_t    ser_defaults;
  int                           num_errors = 0;
  int                           n_compared = 0;
  int                           n_load = 0;
  int                           n_conn = 0;

  always #5 clk_sys = ~clk_sys;

  led_button_model u_led_button_model (.press1(press1), .press2(press2),
    .rgb_n(rgb_n), .switch1_n(switch1_n), .switch2_n(switch2_n), .lit(lit));

  status_ctrl u_status_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .switch1_n(switch1_n), .switch2_n(switch2_n), .op_mode(op_mode),
    .link_state(link_state), .data_activity(data_activity),
    .rgb_n(rgb_n), .connect_req(connect_req),
    .ser_defaults_load(ser_defaults_load), .ser_defaults(ser_defaults),
    .bootloader_active(bootloader_active),
    .factory_reset(factory_reset), .normal_run(normal_run));

  // Pulses last one cycle, so each is seen exactly once at a falling edge.
  always @(negedge clk_sys) begin
    n_load += int'(ser_defaults_load === 1'b1);
    n_conn += int'(connect_req === 1'b1);
  end

  task automatic chk(input string name, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Reset falls half a cycle from any rising edge, so the check just
  // after it shows that it acts without a clock.
  task automatic start(input logic p1, input logic p2);
    @(negedge clk_sys);
    press1 = p1;
    press2 = p2;
    rst_n = 1'b0;
    #1 chk("rgb_in_reset", 8'h07, rgb_n);
    repeat (10) @(negedge clk_sys);
    chk("run_in_reset", 8'h00, normal_run);
    n_load = 0;
    n_conn = 0;
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask : start

  task automatic t_startup;
    start(1'b0, 1'b0);
    chk("normal_plain", 8'h01, normal_run);
    chk("load_plain", 8'h00, n_load[7:0]);
    start(1'b0, 1'b1);
    chk("load_sw2", 8'h01, n_load[7:0]);
    chk("ser_cfg", {status_ctrl_pkg::SER_DATA_BITS,
      status_ctrl_pkg::SER_PARITY_EN, status_ctrl_pkg::SER_STOP_BITS,
      status_ctrl_pkg::SER_FLOW_CTRL_EN}, ser_defaults);
    chk("normal_sw2", 8'h01, normal_run);
    // Letting go after start-up is a rising line: no reload, no request.
    press2 = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("load_once", 8'h01, n_load[7:0]);
    chk("no_conn_release", 8'h00, n_conn[7:0]);
    chk("normal_kept", 8'h01, normal_run);
  endtask : t_startup

  // Every mode against every link state, with the lit colours {r,g,b}.
  task automatic t_colours;
    logic [2:0] exp_lit [9] = '{3'h2, 3'h2, 3'h6, 3'h5, 3'h5, 3'h5,
                                3'h1, 3'h1, 3'h1};
    for (int i = 0; i < 9; i++) begin
      op_mode = status_ctrl_pkg::op_mode_t'(2'(i % 3));
      link_state = status_ctrl_pkg::link_state_t'(2'(i / 3));
      repeat (2) @(negedge clk_sys);
      chk("lit", {5'h00, exp_lit[i]}, {5'h00, lit});
    end
  endtask : t_colours

  task automatic t_flash;
    data_activity = 1'b1;
    @(negedge clk_sys);
    data_activity = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("flash_dark", 8'h00, {5'h00, lit});
    data_activity = 1'b1;
    @(negedge clk_sys);
    data_activity = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk("flash_hold", 8'h00, {5'h00, lit});
  endtask : t_flash

  // The button is let go first, so that the press is a fresh falling
  // edge; only the requests of this press are counted.
  task automatic t_connect(input logic [7:0] e);
    int base;
    press2 = 1'b0;
    @(negedge clk_sys);
    base = n_conn;
    press2 = 1'b1;
    repeat (4) @(negedge clk_sys);
    press2 = 1'b0;
    @(negedge clk_sys);
    chk("connect", e, 8'(n_conn - base));
  endtask : t_connect

  task automatic t_loader;
    start(1'b1, 1'b1);
    chk("loader", 8'h01, bootloader_active);
    chk("loader_run", 8'h00, normal_run);
    chk("factory", 8'h00, factory_reset);
    press2 = 1'b0;
    @(negedge clk_sys);
    t_connect(8'h00);
    chk("loader_kept", 8'h01, bootloader_active);
  endtask : t_loader

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // The run needs well under a thousand cycles; this cuts a hang short.
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    t_startup();
    t_colours();
    t_flash();
    t_connect(8'h01);
    t_loader();
    tally_and_finish();
  end
endmodule : testbench
